/* design/rx_frame_pkg.sv */
package rx_frame_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [5:0] quality_t;
   typedef enum logic [1:0] {LEN_FIXED, LEN_VARIABLE, LEN_INFINITE, LEN_RESERVED} length_mode_t;
   typedef enum logic [1:0] {FILTER_NONE, FILTER_OWN, FILTER_OWN_ZERO, FILTER_OWN_BOTH}
      addr_filter_t;
   typedef enum logic [1:0] {HUNT, RECEIVE, STATUS_RSSI, STATUS_LQI} frame_state_t;
endpackage

/* design/rx_frame_regs.svh */
`ifndef RX_FRAME_REGS_SVH
`define RX_FRAME_REGS_SVH

// Register offsets
`define OFS_SYNC_HIGH    6'h04
`define OFS_SYNC_LOW     6'h05
`define OFS_LIMIT        6'h06
`define OFS_CTRL         6'h07
`define OFS_LEN_CTRL     6'h08
`define OFS_DEV_ADDR     6'h09

// Reset values
`define RST_SYNC_HIGH    8'hd3
`define RST_SYNC_LOW     8'h91
`define RST_LIMIT        8'hff
`define RST_CTRL         8'h04
`define RST_LEN_CTRL     8'h45
`define RST_DEV_ADDR     8'h00

// Writable bits; the rest read as zero
`define WMASK_CTRL       8'hef
`define WMASK_LEN_CTRL   8'h77

// Field positions
`define THRESH_MSB       7
`define THRESH_LSB       5
`define FLUSH_BIT        3
`define APPEND_BIT       2
`define AFM_MSB          1
`define AFM_LSB          0
`define CRC_EN_BIT       2
`define LEN_MSB          1
`define LEN_LSB          0

// Preamble quality arithmetic
`define PQ_UP            6'h01
`define PQ_DOWN          6'h08
`define PQ_MAX           6'h3f
`define THRESH_SCALE_SHIFT 2

// Framing constants
`define BCAST_ZERO       8'h00
`define BCAST_ONES       8'hff
`define BYTE_LAST        3'h7
`define COUNT_STEP       9'h001

`endif

/* design/rx_packet_sync_filter.sv */
`timescale 1ns/1ps
`include "rx_frame_regs.svh"
// How it works
// - High sync byte gives bits 15:8, reset d3
// - Low sync byte gives bits 7:0, reset 91
// - Fixed mode: packet is exactly limit bytes
// - Variable mode: longer than limit is dropped
// - Quality counter plus one on toggled bit
// - Quality counter minus eight on repeated bit
// - Sync allowed once quality reaches four times threshold
// - Zero threshold accepts sync unconditionally
// - Flush FIFO on failed check when enabled
// - Append two status bytes when enabled
// - Status bytes carry strength, quality, check pass
// - Filter mode selects own, zero, ones addresses
// - Own address register resets zero; broadcast 00/ff
// - Length mode: fixed, variable, infinite, reserved
module rx_packet_sync_filter (
   // Clock and reset
   input  wire logic               i_clock,
   input  wire logic               i_resetn,
   // Register port
   input  wire logic [5:0]         i_reg_addr,
   input  wire logic               i_reg_write,
   input  wire rx_frame_pkg::byte_t i_reg_wdata,
   output      rx_frame_pkg::byte_t o_reg_rdata,
   // Demodulated bit stream
   input  wire logic               i_rx_enable,
   input  wire logic               i_bit_valid,
   input  wire logic               i_bit,
   // Link information for status bytes
   input  wire rx_frame_pkg::byte_t i_rssi,
   input  wire logic [6:0]         i_lqi,
   input  wire logic               i_crc_ok,
   // Receive FIFO side
   output      logic               o_fifo_write,
   output      rx_frame_pkg::byte_t o_fifo_data,
   output      logic               o_fifo_flush,
   // Events
   output      logic               o_sync_found,
   output      logic               o_packet_done
);
   import rx_frame_pkg::*;

   byte_t        sync_high_reg;
   byte_t        sync_low_reg;
   byte_t        limit_reg;
   byte_t        ctrl_reg;
   byte_t        len_ctrl_reg;
   byte_t        dev_addr_reg;
   frame_state_t state_reg;
   frame_state_t state_next;
   byte_t        shift_reg;
   logic [2:0]   bit_cnt_reg;
   logic [8:0]   count_reg;
   byte_t        len_reg;
   logic         crc_pass_reg;

   function automatic byte_t masked_write(input byte_t old, input byte_t val, input byte_t mask);
      masked_write = (old & ~mask) | (val & mask);
   endfunction

   function automatic logic addr_ok(input addr_filter_t mode, input byte_t rx, input byte_t own);
      case (mode)
         FILTER_NONE:     addr_ok = 1'b1;
         FILTER_OWN:      addr_ok = rx == own;
         FILTER_OWN_ZERO: addr_ok = rx == own || rx == `BCAST_ZERO;
         FILTER_OWN_BOTH: addr_ok = rx == own || rx == `BCAST_ZERO || rx == `BCAST_ONES;
         default:         addr_ok = 1'b0;
      endcase
   endfunction

   sync_gate_if gate ();
   sync_hunter u_hunter (
      .i_clock  (i_clock),
      .i_resetn (i_resetn),
      .gate     (gate.hunter)
   );

   // Register decode
   wire sel_high  = i_reg_write && i_reg_addr == `OFS_SYNC_HIGH;
   wire sel_low   = i_reg_write && i_reg_addr == `OFS_SYNC_LOW;
   wire sel_limit = i_reg_write && i_reg_addr == `OFS_LIMIT;
   wire sel_ctrl  = i_reg_write && i_reg_addr == `OFS_CTRL;
   wire sel_lenc  = i_reg_write && i_reg_addr == `OFS_LEN_CTRL;
   wire sel_dev   = i_reg_write && i_reg_addr == `OFS_DEV_ADDR;
   // Unmapped offsets read zero
   wire byte_t rdata_next =
      (i_reg_addr == `OFS_SYNC_HIGH) ? sync_high_reg :
      (i_reg_addr == `OFS_SYNC_LOW)  ? sync_low_reg  :
      (i_reg_addr == `OFS_LIMIT)     ? limit_reg     :
      (i_reg_addr == `OFS_CTRL)      ? ctrl_reg      :
      (i_reg_addr == `OFS_LEN_CTRL)  ? len_ctrl_reg  :
      (i_reg_addr == `OFS_DEV_ADDR)  ? dev_addr_reg  : '0;

   // Field decode
   wire               flush_on  = ctrl_reg[`FLUSH_BIT];
   wire               append_on = ctrl_reg[`APPEND_BIT];
   wire addr_filter_t afm       = addr_filter_t'(ctrl_reg[`AFM_MSB:`AFM_LSB]);
   wire length_mode_t len_mode  = length_mode_t'(len_ctrl_reg[`LEN_MSB:`LEN_LSB]);
   wire               crc_en    = len_ctrl_reg[`CRC_EN_BIT];
   wire               variable  = len_mode == LEN_VARIABLE;
   wire               infinite  = len_mode == LEN_INFINITE;

   assign gate.bit_valid = i_bit_valid && i_rx_enable;
   assign gate.bit_value = i_bit;
   assign gate.pattern   = {sync_high_reg, sync_low_reg};
   assign gate.threshold = ctrl_reg[`THRESH_MSB:`THRESH_LSB];

   // Byte assembly, most significant bit first
   wire        receiving  = state_reg == RECEIVE;
   wire        byte_done  = receiving && i_bit_valid && bit_cnt_reg == `BYTE_LAST;
   wire        accept     = byte_done && i_rx_enable;
   wire byte_t rx_byte    = {shift_reg[6:0], i_bit};
   wire [8:0]  count_next = count_reg + `COUNT_STEP;
   wire        sync_hit   = state_reg == HUNT && gate.detect;

   // Reserved length mode behaves as fixed
   wire        is_len_byte  = variable && count_reg == '0;
   wire [8:0]  addr_index   = variable ? `COUNT_STEP : '0;
   wire        is_addr_byte = afm != FILTER_NONE && count_reg == addr_index;
   wire        len_bad      = accept && is_len_byte && (rx_byte > limit_reg || rx_byte == '0);
   wire        addr_bad     = accept && is_addr_byte && !addr_ok(afm, rx_byte, dev_addr_reg);
   wire [8:0]  target       = variable ? {1'b0, len_reg} + `COUNT_STEP : {1'b0, limit_reg};
   wire        last_byte    = accept && !is_len_byte && !infinite && !addr_bad
                              && count_next == target;
   wire        crc_pass     = !crc_en || i_crc_ok;
   // Flush discards the whole FIFO, so the packet must fit in it
   wire        drop_crc     = last_byte && flush_on && !crc_pass;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         HUNT: begin
            if (sync_hit)
               state_next = RECEIVE;
         end
         RECEIVE: begin
            if (len_bad || addr_bad)
               state_next = HUNT;
            else if (last_byte)
               state_next = (append_on && !drop_crc) ? STATUS_RSSI : HUNT;
         end
         STATUS_RSSI: state_next = STATUS_LQI;
         STATUS_LQI:  state_next = HUNT;
         default:     state_next = HUNT;
      endcase
      if (!i_rx_enable)
         state_next = HUNT;
   end

   wire        in_status    = state_reg == STATUS_RSSI || state_reg == STATUS_LQI;
   wire        write_next   = (accept && !len_bad && !addr_bad && !drop_crc) || in_status;
   wire byte_t data_next    = (state_reg == STATUS_RSSI) ? i_rssi :
                              (state_reg == STATUS_LQI)  ? {crc_pass_reg, i_lqi} : rx_byte;
   wire        flush_next   = addr_bad || drop_crc;
   wire        done_next    = (last_byte && !drop_crc && !append_on) || state_reg == STATUS_LQI;

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         sync_high_reg <= `RST_SYNC_HIGH;
         sync_low_reg  <= `RST_SYNC_LOW;
         limit_reg     <= `RST_LIMIT;
         ctrl_reg      <= `RST_CTRL;
         len_ctrl_reg  <= `RST_LEN_CTRL;
         dev_addr_reg  <= `RST_DEV_ADDR;
      end else begin
         if (sel_high)  sync_high_reg <= i_reg_wdata;
         if (sel_low)   sync_low_reg  <= i_reg_wdata;
         if (sel_limit) limit_reg     <= i_reg_wdata;
         if (sel_ctrl)  ctrl_reg      <= masked_write(ctrl_reg, i_reg_wdata, `WMASK_CTRL);
         if (sel_lenc)  len_ctrl_reg  <= masked_write(len_ctrl_reg, i_reg_wdata, `WMASK_LEN_CTRL);
         if (sel_dev)   dev_addr_reg  <= i_reg_wdata;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state_reg    <= HUNT;
         shift_reg    <= '0;
         bit_cnt_reg  <= '0;
         count_reg    <= '0;
         len_reg      <= '0;
         crc_pass_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (sync_hit) begin
            bit_cnt_reg <= '0;
            count_reg   <= '0;
         end else if (receiving && i_bit_valid) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
         end
         if (accept)
            count_reg <= count_next;
         if (accept && is_len_byte)
            len_reg <= rx_byte;
         if (last_byte)
            crc_pass_reg <= crc_pass;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_reg_rdata   <= '0;
         o_fifo_write  <= 1'b0;
         o_fifo_data   <= '0;
         o_fifo_flush  <= 1'b0;
         o_sync_found  <= 1'b0;
         o_packet_done <= 1'b0;
      end else begin
         o_reg_rdata   <= rdata_next;
         o_fifo_write  <= write_next;
         o_fifo_data   <= data_next;
         o_fifo_flush  <= flush_next;
         o_sync_found  <= sync_hit;
         o_packet_done <= done_next;
      end
   end

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   sequence s_end_kept;
      last_byte && !drop_crc && append_on ##1 i_rx_enable ##1 i_rx_enable;
   endsequence
   sequence s_status_pair;
      o_fifo_write && o_fifo_data == $past(i_rssi) ##1
      o_fifo_write && o_fifo_data[6:0] == $past(i_lqi) && o_packet_done;
   endsequence
   // Without status bytes the FIFO port must fall quiet at once
   sequence s_hunt_quiet;
      state_reg == HUNT ##1 !o_fifo_write;
   endsequence

   a_sync_high_byte: assert property (
      sel_high |=> gate.pattern[15:8] == $past(i_reg_wdata))
      else $error("high sync byte not in pattern");
   a_sync_low_byte: assert property (
      sel_low |=> gate.pattern[7:0] == $past(i_reg_wdata))
      else $error("low sync byte not in pattern");
   a_sync_enters_rx: assert property (
      sync_hit && i_rx_enable |=> receiving && o_sync_found)
      else $error("sync hit did not start reception");
   a_fixed_length_end: assert property (
      accept && len_mode == LEN_FIXED && !addr_bad && count_next == {1'b0, limit_reg}
         |=> !receiving)
      else $error("fixed packet did not end at limit");
   a_length_limit: assert property (
      accept && is_len_byte && rx_byte > limit_reg |=> state_reg == HUNT && !o_fifo_write)
      else $error("overlong packet accepted");
   a_crc_flush: assert property (
      drop_crc |=> o_fifo_flush && !o_fifo_write ##1 !o_packet_done)
      else $error("failed packet not flushed");
   a_status_bytes: assert property (
      s_end_kept |-> s_status_pair)
      else $error("status bytes missing after payload");
   a_status_crc_bit: assert property (
      state_reg == STATUS_LQI |=> o_fifo_data[7] == $past(crc_pass_reg))
      else $error("check pass bit wrong in status");
   a_addr_reject: assert property (
      accept && is_addr_byte && afm == FILTER_OWN && rx_byte != dev_addr_reg
         |=> o_fifo_flush && state_reg == HUNT)
      else $error("foreign address not rejected");
   a_addr_broadcast: assert property (
      accept && is_addr_byte && afm == FILTER_OWN_BOTH && rx_byte == `BCAST_ONES
         && !drop_crc |=> !o_fifo_flush)
      else $error("broadcast address rejected");
   a_infinite_runs: assert property (
      accept && infinite && !addr_bad |=> receiving)
      else $error("infinite packet ended by length");
   a_sync_found_pulse: assert property (
      o_sync_found |=> !o_sync_found)
      else $error("sync event held for two cycles");
   a_limit_stored: assert property (
      sel_limit |=> limit_reg == $past(i_reg_wdata))
      else $error("length limit not stored");
   a_var_length_end: assert property (
      accept && variable && !is_len_byte && !addr_bad
         && count_next == {1'b0, len_reg} + `COUNT_STEP |=> !receiving)
      else $error("variable packet did not end at its length");
   a_len_zero_reject: assert property (
      accept && is_len_byte && rx_byte == '0 |=> state_reg == HUNT && !o_fifo_write)
      else $error("zero length packet accepted");
   a_flush_off_keep: assert property (
      last_byte && !flush_on |=> o_fifo_write && !o_fifo_flush)
      else $error("packet lost with flush disabled");
   a_ctrl_write_mask: assert property (
      sel_ctrl |=> ctrl_reg == ($past(i_reg_wdata) & `WMASK_CTRL))
      else $error("control write not stored as masked");
   a_status_off: assert property (
      last_byte && !append_on |=> s_hunt_quiet)
      else $error("status bytes written while disabled");
   a_done_with_write: assert property (
      o_packet_done |-> o_fifo_write)
      else $error("packet end without a FIFO write");
   a_status_rssi: assert property (
      state_reg == STATUS_RSSI |=> o_fifo_write && o_fifo_data == $past(i_rssi))
      else $error("strength byte missing from status");
   a_addr_zero_bcast: assert property (
      accept && is_addr_byte && afm == FILTER_OWN_ZERO && rx_byte == `BCAST_ZERO
         && !drop_crc |=> !o_fifo_flush)
      else $error("zero broadcast address rejected");
   a_own_addr_pass: assert property (
      accept && is_addr_byte && rx_byte == dev_addr_reg && !drop_crc |=> !o_fifo_flush)
      else $error("own address rejected");
   a_reserved_fixed: assert property (
      accept && len_mode == LEN_RESERVED && !addr_bad && count_next == {1'b0, limit_reg}
         |=> !receiving)
      else $error("reserved mode did not end at limit");
endmodule

/* design/sync_gate_if.sv */
`timescale 1ns/1ps
interface sync_gate_if;
   logic        bit_valid;
   logic        bit_value;
   logic [15:0] pattern;
   logic [2:0]  threshold;
   logic        detect;
   logic [5:0]  quality;
   modport hunter (
      input  bit_valid, bit_value, pattern, threshold,
      output detect, quality
   );
   modport framer (
      output bit_valid, bit_value, pattern, threshold,
      input  detect, quality
   );
endinterface

/* design/sync_hunter.sv */
`timescale 1ns/1ps
`include "rx_frame_regs.svh"
module sync_hunter (
   // Clock and reset
   input  wire logic   i_clock,
   input  wire logic   i_resetn,
   // Bit stream and match result
   sync_gate_if.hunter gate
);
   import rx_frame_pkg::*;

   logic [15:0] window_reg;
   logic        prev_reg;
   quality_t    quality_reg;

   function automatic quality_t quality_step(input quality_t q, input logic toggled);
      if (toggled)
         quality_step = (q == `PQ_MAX) ? q : q + `PQ_UP;
      else
         quality_step = (q < `PQ_DOWN) ? '0 : q - `PQ_DOWN;
   endfunction

   wire [15:0] window_next = {window_reg[14:0], gate.bit_value};
   wire        toggled     = gate.bit_value != prev_reg;
   wire quality_t need     = quality_t'({3'h0, gate.threshold} << `THRESH_SCALE_SHIFT);
   // Zero threshold opens the gate unconditionally
   wire        gate_open   = (gate.threshold == '0) || (quality_reg >= need);
   assign gate.detect  = gate.bit_valid && (window_next == gate.pattern) && gate_open;
   assign gate.quality = quality_reg;

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         window_reg  <= '0;
         prev_reg    <= 1'b0;
         quality_reg <= '0;
      end else if (gate.bit_valid) begin
         window_reg  <= window_next;
         prev_reg    <= gate.bit_value;
         quality_reg <= quality_step(quality_reg, toggled);
      end
   end

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   a_sync_window_match: assert property (
      gate.detect |=> window_reg == $past(gate.pattern))
      else $error("sync declared without matching window");
   a_quality_rises: assert property (
      gate.bit_valid && toggled && quality_reg < `PQ_MAX |=>
         quality_reg == $past(quality_reg) + `PQ_UP)
      else $error("quality did not rise on a toggled bit");
   a_quality_falls: assert property (
      gate.bit_valid && !toggled && quality_reg >= `PQ_DOWN |=>
         quality_reg == $past(quality_reg) - `PQ_DOWN)
      else $error("quality did not fall by eight on a repeated bit");
   a_gate_threshold: assert property (
      gate.detect && gate.threshold != '0 |-> quality_reg >= need)
      else $error("sync passed below quality threshold");
   a_gate_open_zero: assert property (
      gate.bit_valid && gate.threshold == '0 && window_next == gate.pattern |-> gate.detect)
      else $error("sync refused with zero threshold");
endmodule

/* tb/fifo_host_model.sv */
`timescale 1ns/1ps
module fifo_host_model (
   // Clock
   input  wire logic                i_clock,
   // Device FIFO port and events
   input  wire logic                i_fifo_write,
   input  wire rx_frame_pkg::byte_t i_fifo_data,
   input  wire logic                i_fifo_flush,
   input  wire logic                i_sync_found,
   input  wire logic                i_packet_done
);
   import rx_frame_pkg::*;
   byte_t q[$];
   int    syncs   = 0;
   int    dones   = 0;
   int    flushes = 0;
   always @(posedge i_clock) begin
      // Flush empties everything: host keeps at most one packet queued
      if (i_fifo_flush) begin
         q.delete();
      end else if (i_fifo_write) begin
         q.push_back(i_fifo_data);
      end
      syncs   <= syncs + int'(i_sync_found);
      dones   <= dones + int'(i_packet_done);
      flushes <= flushes + int'(i_fifo_flush);
   end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import rx_frame_pkg::*;
   logic       i_clock     = 1'b0;
   logic       i_resetn    = 1'b0;
   logic [5:0] i_reg_addr  = 6'h00;
   logic       i_reg_write = 1'b0;
   byte_t      i_reg_wdata = 8'h00;
   logic       i_rx_enable = 1'b0;
   logic       i_bit_valid = 1'b0;
   logic       i_bit       = 1'b0;
   byte_t      i_rssi      = 8'h7e;
   logic [6:0] i_lqi       = 7'h15;
   logic       i_crc_ok    = 1'b1;
   byte_t      o_reg_rdata;
   byte_t      o_fifo_data;
   logic       o_fifo_write;
   logic       o_fifo_flush;
   logic       o_sync_found;
   logic       o_packet_done;
   logic       ok;
   int         miscompares = 0;
   int         tests_run   = 0;
   int         s0, d0, f0;
   byte_t      lm[2]  = '{8'h44, 8'h47};
   byte_t      adr[4] = '{8'h42, 8'h00, 8'hff, 8'h17};

   always #25 i_clock = ~i_clock;

   rx_packet_sync_filter rx_packet_sync_filter_i (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
      .i_reg_write(i_reg_write), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .i_rx_enable(i_rx_enable), .i_bit_valid(i_bit_valid), .i_bit(i_bit),
      .i_rssi(i_rssi), .i_lqi(i_lqi), .i_crc_ok(i_crc_ok),
      .o_fifo_write(o_fifo_write), .o_fifo_data(o_fifo_data), .o_fifo_flush(o_fifo_flush),
      .o_sync_found(o_sync_found), .o_packet_done(o_packet_done));

   fifo_host_model fifo_host_model_i (
      .i_clock(i_clock), .i_fifo_write(o_fifo_write), .i_fifo_data(o_fifo_data),
      .i_fifo_flush(o_fifo_flush), .i_sync_found(o_sync_found),
      .i_packet_done(o_packet_done));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [5:0] a, input byte_t d);
      @(posedge i_clock);
      i_reg_addr  <= a;
      i_reg_write <= 1'b1;
      i_reg_wdata <= d;
      @(posedge i_clock);
      i_reg_write <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input byte_t e);
      @(posedge i_clock);
      i_reg_addr <= a;
      repeat (2) @(posedge i_clock);
      #1;
      check("reg_rdata", {8'h00, o_reg_rdata}, {8'h00, e});
   endtask

   // Bits go out MSB first, one per cycle
   task automatic send(input logic [15:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge i_clock);
         i_bit_valid <= 1'b1;
         i_bit       <= v[i];
      end
      @(posedge i_clock);
      i_bit_valid <= 1'b0;
   endtask

   // Sixteen repeated bits first, so the quality count starts from zero
   task automatic frame(input logic [15:0] sw, input byte_t b[$]);
      fifo_host_model_i.q.delete();
      s0 = fifo_host_model_i.syncs;
      d0 = fifo_host_model_i.dones;
      f0 = fifo_host_model_i.flushes;
      send(16'h0000, 16);
      send(sw, 16);
      foreach (b[i]) send({8'h00, b[i]}, 8);
      repeat (6) @(posedge i_clock);
   endtask

   task automatic qchk(input byte_t e[$]);
      check("fifo_count", 16'(fifo_host_model_i.q.size()), 16'(e.size()));
      foreach (e[i]) begin
         if (i < fifo_host_model_i.q.size()) begin
            check("fifo_byte", {8'h00, fifo_host_model_i.q[i]}, {8'h00, e[i]});
         end
      end
   endtask

   task automatic ev(input int ns, input int nd, input int nf);
      check("sync_count", 16'(fifo_host_model_i.syncs - s0), 16'(ns));
      check("done_count", 16'(fifo_host_model_i.dones - d0), 16'(nd));
      check("flush_count", 16'(fifo_host_model_i.flushes - f0), 16'(nf));
   endtask

   task automatic end_of_test();
      $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge i_clock);
      miscompares++;
      end_of_test();
   end

   initial begin
      repeat (8) @(posedge i_clock);
      i_resetn    <= 1'b1;
      i_rx_enable <= 1'b1;
      rd(6'h04, 8'hd3);
      rd(6'h05, 8'h91);
      rd(6'h06, 8'hff);
      rd(6'h07, 8'h04);
      rd(6'h08, 8'h45);
      rd(6'h09, 8'h00);
      wr(6'h07, 8'hff);
      rd(6'h07, 8'hef);
      wr(6'h08, 8'hff);
      rd(6'h08, 8'h77);
      wr(6'h0a, 8'h5a);
      rd(6'h0a, 8'h00);
      wr(6'h06, 8'h02);
      wr(6'h07, 8'h04);
      // Fixed mode, then reserved mode which behaves as fixed
      foreach (lm[k]) begin
         wr(6'h08, lm[k]);
         frame(16'hd391, '{8'ha5, 8'h3c});
         qchk('{8'ha5, 8'h3c, 8'h7e, 8'h95});
         ev(1, 1, 0);
      end
      i_crc_ok <= 1'b0;
      wr(6'h08, 8'h44);
      frame(16'hd391, '{8'ha5, 8'h3c});
      qchk('{8'ha5, 8'h3c, 8'h7e, 8'h15});
      wr(6'h07, 8'h0c);
      frame(16'hd391, '{8'ha5, 8'h3c});
      check("fifo_count", 16'(fifo_host_model_i.q.size()), 16'h0000);
      ev(1, 0, 1);
      i_crc_ok <= 1'b1;
      wr(6'h06, 8'h01);
      wr(6'h09, 8'h42);
      for (int m = 0; m < 4; m++) begin
         foreach (adr[j]) begin
            wr(6'h07, {6'h00, 2'(m)});
            frame(16'hd391, '{adr[j]});
            ok = (m == 0) || (adr[j] == 8'h42) || (m >= 2 && adr[j] == 8'h00)
                 || (m == 3 && adr[j] == 8'hff);
            check("fifo_count", 16'(fifo_host_model_i.q.size()), {15'h0000, ok});
            ev(1, int'(ok), int'(!ok));
         end
      end
      wr(6'h08, 8'h45);
      wr(6'h06, 8'h02);
      wr(6'h07, 8'h04);
      frame(16'hd391, '{8'h03, 8'h11, 8'h22, 8'h33});
      check("fifo_count", 16'(fifo_host_model_i.q.size()), 16'h0000);
      ev(1, 0, 0);
      frame(16'hd391, '{8'h00});
      check("fifo_count", 16'(fifo_host_model_i.q.size()), 16'h0000);
      frame(16'hd391, '{8'h02, 8'h11, 8'h22});
      qchk('{8'h02, 8'h11, 8'h22, 8'h7e, 8'h95});
      ev(1, 1, 0);
      wr(6'h08, 8'h46);
      frame(16'hd391, '{8'h11, 8'h22, 8'h33});
      qchk('{8'h11, 8'h22, 8'h33});
      ev(1, 0, 0);
      i_rx_enable <= 1'b0;
      @(posedge i_clock);
      i_rx_enable <= 1'b1;
      // Pattern carries 15 toggles before its last bit: passes 4*3, fails 4*4
      wr(6'h08, 8'h44);
      wr(6'h06, 8'h01);
      wr(6'h04, 8'haa);
      wr(6'h05, 8'hab);
      for (int p = 3; p < 5; p++) begin
         wr(6'h07, {3'(p), 5'h00});
         frame(16'haaab, '{8'h5a});
         check("sync_count", 16'(fifo_host_model_i.syncs - s0), 16'(p == 3));
         check("fifo_count", 16'(fifo_host_model_i.q.size()), 16'(p == 3));
      end
      end_of_test();
   end
endmodule
